// >>> cip_capture_prio.sv
`timescale 1ns/1ps
`include "cip_regs.svh"

module cip_capture_prio
  import cip_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // levels toward the interrupt arbiter
  output cip_level_t capture_ch3_level,
  output cip_level_t capture_ch4_level,
  output cip_level_t capture_ch5_level,
  // source enables toward the arbiter, low when the code is 000
  output logic [2:0] capture_src_enabled
);

  // the slave is written for a 32-bit data bus and word addressing
  if (DATA_W != 32) begin : g_bad_data_w
    $error("cip_capture_prio supports only a 32-bit data bus");
  end
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
    $error("cip_capture_prio needs an address width of 3 to 32 bits");
  end

  localparam int NFIELD = 3;
  localparam int FIELD_LSB [NFIELD] = '{`CIP_CH3_LSB, `CIP_CH4_LSB, `CIP_CH5_LSB};

  // word decode shared by the read and write paths
  function automatic logic hits_reg(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    return ((wide >> 2) == (`CIP_PRIO_OFFSET >> 2));
  endfunction

  // write channel state
  cip_wr_state_t wr_state_r;
  cip_wr_state_t wr_state_nxt;
  logic aw_have_r;
  logic aw_have_nxt;
  logic w_have_r;
  logic w_have_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [ADDR_W-1:0] aw_addr_nxt;
  logic [DATA_W-1:0] w_data_r;
  logic [DATA_W-1:0] w_data_nxt;
  logic [DATA_W/8-1:0] w_strb_r;
  logic [DATA_W/8-1:0] w_strb_nxt;
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic reg_wr_en;

  // read channel state
  cip_rd_state_t rd_state_r;
  cip_rd_state_t rd_state_nxt;
  logic arready_r;
  logic arready_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  // register image assembled from the field flops
  cip_level_t field_level [NFIELD];
  logic [NFIELD-1:0] field_en;
  logic [`CIP_REG_W-1:0] reg_image;

  // address and data may arrive in either order; the write fires once both are held
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    reg_wr_en = 1'b0;
    case (wr_state_r)
      CIP_WR_COLLECT: begin
        if (s_axi_awvalid && awready_r) begin
          aw_have_nxt = 1'b1;
          aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
          w_have_nxt = 1'b1;
          w_data_nxt = s_axi_wdata;
          w_strb_nxt = s_axi_wstrb;
        end
        if (aw_have_r && w_have_r) begin
          reg_wr_en = hits_reg(aw_addr_r);
          bresp_nxt = hits_reg(aw_addr_r) ? `CIP_RESP_OKAY : `CIP_RESP_DECERR;
          bvalid_nxt = 1'b1;
          aw_have_nxt = 1'b0;
          w_have_nxt = 1'b0;
          wr_state_nxt = CIP_WR_RESP;
        end
      end
      CIP_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt = 1'b0;
          wr_state_nxt = CIP_WR_COLLECT;
        end
      end
      default: begin
        wr_state_nxt = CIP_WR_COLLECT;
        bvalid_nxt = 1'b0;
      end
    endcase
    // each ready stays low while its half is held or a response is pending
    awready_nxt = (wr_state_nxt == CIP_WR_COLLECT) && !aw_have_nxt;
    wready_nxt = (wr_state_nxt == CIP_WR_COLLECT) && !w_have_nxt;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_state_r <= CIP_WR_COLLECT;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `CIP_RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // one field unit per capture channel; writes outside the mask have no flop to land in
  for (genvar i = 0; i < NFIELD; i++) begin : g_field
    cip_prio_field #(
      .LSB(FIELD_LSB[i])
    ) u_field (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(reg_wr_en),
      .wr_data(w_data_r),
      .wr_strb(w_strb_r),
      .level(field_level[i]),
      .enabled(field_en[i])
    );
  end

  // unimplemented bits are tied low in the read image
  always_comb begin
    reg_image = '0;
    for (int i = 0; i < NFIELD; i++) begin
      reg_image[FIELD_LSB[i] +: `CIP_FIELD_W] = field_level[i];
    end
    reg_image = reg_image & `CIP_REG_MASK;
  end

  // read answers one cycle after the address is taken; the image is sampled at the address handshake
  always_comb begin
    rd_state_nxt = rd_state_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_state_r)
      CIP_RD_IDLE: begin
        if (s_axi_arvalid && arready_r) begin
          rvalid_nxt = 1'b1;
          if (hits_reg(s_axi_araddr)) begin
            rdata_nxt = 32'(reg_image);
            rresp_nxt = `CIP_RESP_OKAY;
          end else begin
            rdata_nxt = '0;
            rresp_nxt = `CIP_RESP_DECERR;
          end
          rd_state_nxt = CIP_RD_RESP;
        end
      end
      CIP_RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_nxt = 1'b0;
          rd_state_nxt = CIP_RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = CIP_RD_IDLE;
        rvalid_nxt = 1'b0;
      end
    endcase
    arready_nxt = (rd_state_nxt == CIP_RD_IDLE);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_state_r <= CIP_RD_IDLE;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `CIP_RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // protection bits carry no meaning for this register
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // bus outputs all come from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // levels pass code-for-level; a disabled source is flagged so it can never win
  assign capture_ch3_level = field_level[0];
  assign capture_ch4_level = field_level[1];
  assign capture_ch5_level = field_level[2];
  assign capture_src_enabled = field_en;

endmodule

// >>> cip_regs.svh
`ifndef CIP_PRIO_REGS_SVH
`define CIP_PRIO_REGS_SVH

// byte address of the capture priority register on the bus
`define CIP_PRIO_OFFSET 32'h0000_0000
// field positions inside the 16-bit register
`define CIP_CH3_LSB 4
`define CIP_CH4_LSB 8
`define CIP_CH5_LSB 12
`define CIP_FIELD_W 3
// value every priority field takes at reset
`define CIP_FIELD_RESET 3'h4
// code that turns a source off
`define CIP_LEVEL_OFF 3'h0
// implemented bits of the register
`define CIP_REG_MASK 16'h7770
`define CIP_REG_W 16
// bus answer codes
`define CIP_RESP_OKAY 2'h0
`define CIP_RESP_DECERR 2'h3

`endif

// >>> cip_pkg.sv
package cip_pkg;

  typedef logic [2:0] cip_level_t;

  typedef enum logic [0:0] {
    CIP_WR_COLLECT,
    CIP_WR_RESP
  } cip_wr_state_t;

  typedef enum logic [0:0] {
    CIP_RD_IDLE,
    CIP_RD_RESP
  } cip_rd_state_t;

endpackage

// >>> cip_prio_field.sv
`timescale 1ns/1ps
`include "cip_regs.svh"

// one 3-bit priority field with its byte-lane write and its enable flag
module cip_prio_field
  import cip_pkg::*;
#(
  parameter int LSB = `CIP_CH3_LSB
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  output cip_level_t level,
  output logic enabled
);

  cip_level_t field_r;
  cip_level_t field_nxt;
  logic enabled_r;
  logic enabled_nxt;

  // one strobe bit guards the field, so it must not cross a byte lane
  if (LSB < 0 || LSB + `CIP_FIELD_W > 32 || (LSB % 8) + `CIP_FIELD_W > 8) begin : g_bad_lsb
    $error("cip_prio_field needs its field inside one byte lane");
  end

  // a field never straddles a byte lane, so one strobe bit guards it
  always_comb begin
    field_nxt = field_r;
    if (wr_en && wr_strb[LSB / 8]) begin
      field_nxt = wr_data[LSB +: `CIP_FIELD_W];
    end
    enabled_nxt = (field_nxt != `CIP_LEVEL_OFF);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      field_r <= `CIP_FIELD_RESET;
      enabled_r <= 1'b1;
    end else begin
      field_r <= field_nxt;
      enabled_r <= enabled_nxt;
    end
  end

  // code equals level: 001 lowest, 111 highest
  assign level = field_r;
  assign enabled = enabled_r;

endmodule

// >>> cip_capture_prio_monitor.sv
`timescale 1ns/1ps

module cip_capture_prio_monitor
  import cip_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cip_level_t capture_ch3_level,
  input wire cip_level_t capture_ch4_level,
  input wire cip_level_t capture_ch5_level,
  input wire logic [2:0] capture_src_enabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // enable flags follow the codes, off only at 000
  a_src_enable: assert property (
    capture_src_enabled == {capture_ch5_level != 3'h0, capture_ch4_level != 3'h0,
    capture_ch3_level != 3'h0}) else $error("enable flags disagree with codes");
  // first cycle after reset shows every field at 100
  a_reset_code: assert property (
    $past(sys_rst) |-> capture_ch3_level == 3'h4 && capture_ch4_level == 3'h4 &&
    capture_ch5_level == 3'h4) else $error("field not 100 after reset");
  // read data is the image as it stood at the address edge
  a_read_image: assert property (
    $rose(s_axi_rvalid) && s_axi_rdata != 32'h0 |-> s_axi_rdata[15:0] == {1'b0,
    $past(capture_ch5_level), 1'b0, $past(capture_ch4_level), 1'b0,
    $past(capture_ch3_level), 4'h0}) else $error("read image mismatch");
  a_read_zeros: assert property (
    s_axi_rvalid |-> (s_axi_rdata & 32'hffff_888f) == 32'h0) else $error("unused bit set");
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  // levels only move on the cycle the write response appears
  a_level_commit: assert property (
    $changed({capture_ch5_level, capture_ch4_level, capture_ch3_level}) |->
    $rose(s_axi_bvalid)) else $error("level moved outside a write");
  a_b_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid lingers");
  a_r_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid lingers");

  c_write: cover property ($rose(s_axi_bvalid));
  c_top: cover property (s_axi_rvalid && s_axi_rdata[14:12] == 3'h7);
  c_all_off: cover property (capture_src_enabled == 3'h0);
endmodule

bind cip_capture_prio cip_capture_prio_monitor #(.DATA_W(DATA_W)) cip_capture_prio_monitor_i (
  .clock, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .capture_ch3_level, .capture_ch4_level,
  .capture_ch5_level, .capture_src_enabled);

// >>> testbench.sv
`timescale 1ns/1ps

module testbench import cip_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  cip_level_t capture_ch3_level, capture_ch4_level, capture_ch5_level;
  logic [2:0] capture_src_enabled;
  int n_mismatch = 0;
  int n_compared = 0;
  // rows: strobes, write data, register image expected afterwards
  logic [35:0] rows [7] = '{36'hf_ffff_7770, 36'h3_1110_1110, 36'h1_0000_1100,
    36'h2_2350_2300, 36'h1_6650_2350, 36'h3_0060_0060, 36'h3_0000_0000};

  cip_capture_prio cip_capture_prio_i (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .capture_ch3_level, .capture_ch4_level, .capture_ch5_level, .capture_src_enabled);

  // 10 MHz clock
  initial forever #50 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once its ready is seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // arbiter-side outputs against a 16-bit register image
  task automatic chk_out(input logic [15:0] im);
    chk("ch3 level", 32'(capture_ch3_level), 32'(im[6:4]));
    chk("ch4 level", 32'(capture_ch4_level), 32'(im[10:8]));
    chk("ch5 level", 32'(capture_ch5_level), 32'(im[14:12]));
    chk("enables", 32'(capture_src_enabled), 32'({|im[14:12], |im[10:8], |im[6:4]}));
  endtask

  // main sequence: reset, table rows, unmapped words, reset in mid-run
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk_out(16'h4440);
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, {16'hffff, rows[i][31:16]}, rows[i][35:32]);
      chk("bresp", 32'(resp), 32'h0);
      chk_out(rows[i][15:0]);
      rd(4'h0);
      chk("rdata", rd_val, {16'h0, rows[i][15:0]});
    end
    wr(4'h4, 32'h7770, 4'hf);
    chk("bad bresp", 32'(resp), 32'h3);
    rd(4'h8);
    chk("bad rresp", 32'(resp), 32'h3);
    chk("bad rdata", rd_val, 32'h0);
    chk_out(16'h0000);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk_out(16'h4440);
    rd(4'h0);
    chk("reset image", rd_val, 32'h4440);
    final_report;
  end

  // watchdog: the run needs about 50 cycles, allow 1000
  initial begin
    #100_000;
    n_mismatch++;
    final_report;
  end
endmodule
